//--- inc/adm_consts.svh
// constants for the converter output demux and reset alignment block
// assumes one sample clock domain; counts are in sample clock cycles
`ifndef ADM_CONSTS_SVH
`define ADM_CONSTS_SVH

`define ADM_CODE_W      8
`define ADM_DIFF_W      9
`define ADM_DIFF_POS_FS 9'sh080
`define ADM_DIFF_NEG_FS 9'sh180
`define ADM_DIFF_ZERO   9'sh000
`define ADM_CODE_OFFSET 9'h080
`define ADM_CODE_TOP    8'hFF
`define ADM_CODE_BOT    8'h00
`define ADM_CODE_MID_LO 8'h7F
`define ADM_CODE_MID_HI 8'h80
`define ADM_DATA_PIPE   5
`define ADM_RST_PIPE    4
`define ADM_RST_OUT_LAT 5
`define ADM_CNT_RST     2'h0
`define ADM_CNT_STEP    2'h1
`define ADM_CNT_LAST    2'h3

`endif

//--- inc/adm_pkg.sv
// shared types for the converter output demux block
// assumes adm_consts.svh is on the include path
`include "adm_consts.svh"

package adm_pkg;

  typedef struct packed {
    logic                   ovr;
    logic [`ADM_CODE_W-1:0] code;
  } adm_sample_s;

  typedef enum logic [1:0] {
    ADM_SINGLE_RATE_MODE,
    ADM_HALF_RATE_MODE,
    ADM_QUARTER_DECIMATE_MODE
  } adm_mode_e;

endpackage

//--- hw/adm_delay_line.sv
// fixed-depth shift register used for data and reset latency matching
// assumes a single clock and an asynchronous active-high reset
module adm_delay_line #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] stage_reg [DEPTH];
  logic [WIDTH-1:0] stage_in  [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      if (g == 0) begin : g_head
        assign stage_in[g] = i_d;
      end else begin : g_body
        assign stage_in[g] = stage_reg[g-1];
      end
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          stage_reg[g] <= '0;
        end else begin
          stage_reg[g] <= stage_in[g];
        end
      end
    end
  endgenerate

  assign o_q = stage_reg[DEPTH-1];

endmodule

//--- hw/adm_top.sv
// output coding, 1:2 demultiplexer, clock divider and demux reset path
// assumes I_CLK is the sample clock and all inputs are synchronous to it
//
// Notes on behaviour
// - codes are offset binary; positive full scale sets overrange; zero toggles 7F/80.
// - each sample is taken on the rising sample clock edge.
// - outside single rate, output ports change only where the data-ready clock rises.
// - demultiplexed operation splits samples two ways, each port at half or quarter rate.
// - demux reset input is captured on the rising sample clock edge.
// - an undriven reset input pair reads as deasserted.
// - latched reset holds the internal demultiplexer in reset.
// - captured reset runs through a pipeline one stage shorter than the data latency.
// - reset output edge lines up with data sampled at reset release.
// - a complementary reset output pair feeds external demultiplexers.
// - divider makes single, half or quarter rate data-ready clock from selects.
// - after power-up the half-rate clock may start in either phase.
// - asserted reset forces the divider counter to a known phase.
// - enable low gives single rate; high with select low half; both quarter.
// - single rate bypasses demux; auxiliary repeats primary one cycle late.
// - half rate shows newer sample on primary, older on auxiliary.
// - quarter rate drops every other sample and demultiplexes the rest.
`include "adm_consts.svh"

module adm_top (
  input  wire logic                         I_CLK,
  input  wire logic                         I_RST,
  input  wire logic signed [`ADM_DIFF_W-1:0] I_CONV_DIFF,
  input  wire logic                         I_DEMUX_RESET_IN_P,
  input  wire logic                         I_DEMUX_RESET_IN_N,
  input  wire logic                         I_DEMUX_ENABLE_SELECT,
  input  wire logic                         I_DIVIDE_RATIO_SELECT,
  input  wire logic                         I_PHASE_STRAP,
  output logic      [`ADM_CODE_W-1:0]       O_PRIM_DATA,
  output logic      [`ADM_CODE_W-1:0]       O_AUX_DATA,
  output logic                              O_OVERRANGE,
  output logic                              O_DREADY,
  output logic                              O_DREADY_N,
  output logic                              O_DATA_VALID,
  output logic                              O_DEMUX_RESET_OUT,
  output logic                              O_DEMUX_RESET_OUT_N
);

  adm_pkg::adm_mode_e   mode_w;
  adm_pkg::adm_sample_s code_next;
  adm_pkg::adm_sample_s code_reg;
  adm_pkg::adm_sample_s dly_w;
  adm_pkg::adm_sample_s hist1_reg;
  adm_pkg::adm_sample_s hist2_reg;
  logic [8:0]             sum_w;
  logic                   zero_w;
  logic                   zero_tgl_reg;
  logic                   rst_in_w;
  logic                   rst_lat_reg;
  logic                   rst_dly_w;
  logic                   strap_done_reg;
  logic [1:0]             cnt_reg;
  logic [1:0]             cnt_next;
  logic                   upd_w;
  logic                   dready_next;
  logic [`ADM_CODE_W-1:0] prim_next;
  logic [`ADM_CODE_W-1:0] aux_next;
  logic                   ovr_next;

  // mode decode
  assign mode_w = !I_DEMUX_ENABLE_SELECT ? adm_pkg::ADM_SINGLE_RATE_MODE :
                  I_DIVIDE_RATIO_SELECT  ? adm_pkg::ADM_QUARTER_DECIMATE_MODE :
                                           adm_pkg::ADM_HALF_RATE_MODE;

  // open inputs bias negative, so only a true high-low pair counts
  assign rst_in_w = I_DEMUX_RESET_IN_P & ~I_DEMUX_RESET_IN_N;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rst_lat_reg <= 1'b0;
    end else begin
      rst_lat_reg <= rst_in_w;
    end
  end

  // output coder
  assign sum_w  = I_CONV_DIFF + `ADM_CODE_OFFSET;
  assign zero_w = (I_CONV_DIFF == `ADM_DIFF_ZERO);

  always_comb begin
    code_next.ovr  = 1'b0;
    code_next.code = sum_w[`ADM_CODE_W-1:0];
    if (I_CONV_DIFF >= `ADM_DIFF_POS_FS) begin
      code_next.code = `ADM_CODE_TOP;
      code_next.ovr  = 1'b1;
    end else if (I_CONV_DIFF <= `ADM_DIFF_NEG_FS) begin
      code_next.code = `ADM_CODE_BOT;
    end else if (zero_w) begin
      // midscale dithers between the two codes either side of zero
      code_next.code = zero_tgl_reg ? `ADM_CODE_MID_HI : `ADM_CODE_MID_LO;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      code_reg     <= '0;
      zero_tgl_reg <= 1'b0;
    end else begin
      code_reg     <= code_next;
      zero_tgl_reg <= zero_tgl_reg ^ zero_w;
    end
  end

  // divider counter; strap stands in for the random power-up phase
  assign cnt_next = rst_lat_reg     ? `ADM_CNT_RST :
                    !strap_done_reg ? {1'b0, I_PHASE_STRAP} :
                                      cnt_reg + `ADM_CNT_STEP;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_reg        <= `ADM_CNT_RST;
      strap_done_reg <= 1'b0;
    end else begin
      cnt_reg        <= cnt_next;
      strap_done_reg <= 1'b1;
    end
  end

  // port update points; reset parks the counter where none fires outside single rate
  assign upd_w = (mode_w == adm_pkg::ADM_SINGLE_RATE_MODE) ? 1'b1 :
                 (mode_w == adm_pkg::ADM_HALF_RATE_MODE)   ? cnt_reg[0] :
                 (cnt_reg == `ADM_CNT_LAST);

  // single rate toggles at half the clock: no flop can run at full rate
  assign dready_next = (mode_w == adm_pkg::ADM_SINGLE_RATE_MODE) ? ~O_DREADY :
                       (mode_w == adm_pkg::ADM_HALF_RATE_MODE)   ? cnt_reg[0] :
                       ~(cnt_reg[1] ^ cnt_reg[0]);

  // data latency pipe
  adm_delay_line #(
    .DEPTH (`ADM_DATA_PIPE),
    .WIDTH ($bits(adm_pkg::adm_sample_s))
  ) u_data_dly (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (code_reg),
    .o_q   (dly_w)
  );

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hist1_reg <= '0;
      hist2_reg <= '0;
    end else begin
      hist1_reg <= dly_w;
      hist2_reg <= hist1_reg;
    end
  end

  // demultiplexer selection
  always_comb begin
    prim_next = O_PRIM_DATA;
    aux_next  = O_AUX_DATA;
    ovr_next  = O_OVERRANGE;
    case (mode_w)
      adm_pkg::ADM_SINGLE_RATE_MODE: begin
        prim_next = dly_w.code;
        aux_next  = O_PRIM_DATA;
        ovr_next  = dly_w.ovr;
      end
      adm_pkg::ADM_HALF_RATE_MODE: begin
        if (upd_w) begin
          prim_next = dly_w.code;
          aux_next  = hist1_reg.code;
          ovr_next  = dly_w.ovr | hist1_reg.ovr;
        end
      end
      adm_pkg::ADM_QUARTER_DECIMATE_MODE: begin
        if (upd_w) begin
          // skipping hist1 drops the sample between the two kept ones
          prim_next = dly_w.code;
          aux_next  = hist2_reg.code;
          ovr_next  = dly_w.ovr | hist2_reg.ovr;
        end
      end
      default: begin
        prim_next = O_PRIM_DATA;
      end
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRIM_DATA  <= '0;
      O_AUX_DATA   <= '0;
      O_OVERRANGE  <= 1'b0;
      O_DREADY     <= 1'b0;
      O_DREADY_N   <= 1'b1;
      O_DATA_VALID <= 1'b0;
    end else begin
      O_PRIM_DATA  <= prim_next;
      O_AUX_DATA   <= aux_next;
      O_OVERRANGE  <= ovr_next;
      O_DREADY     <= dready_next;
      O_DREADY_N   <= ~dready_next;
      O_DATA_VALID <= upd_w;
    end
  end

  // reset pipe is one stage shorter so its edge marks aligned data
  adm_delay_line #(
    .DEPTH (`ADM_RST_PIPE),
    .WIDTH (1)
  ) u_rst_dly (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (rst_lat_reg),
    .o_q   (rst_dly_w)
  );

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DEMUX_RESET_OUT   <= 1'b0;
      O_DEMUX_RESET_OUT_N <= 1'b1;
    end else begin
      O_DEMUX_RESET_OUT   <= rst_dly_w;
      O_DEMUX_RESET_OUT_N <= ~rst_dly_w;
    end
  end

  // checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_rst_release;
    rst_lat_reg ##1 !rst_lat_reg;
  endsequence

  sequence s_half_run;
    (mode_w == adm_pkg::ADM_HALF_RATE_MODE && !rst_lat_reg)[*2];
  endsequence

  a_code_top: assert property (
    I_CONV_DIFF >= `ADM_DIFF_POS_FS |=> code_reg.code == `ADM_CODE_TOP && code_reg.ovr)
    else $error("positive full scale not coded as top code with overrange");

  a_code_bottom: assert property (
    I_CONV_DIFF <= `ADM_DIFF_NEG_FS |=> code_reg.code == `ADM_CODE_BOT && !code_reg.ovr)
    else $error("negative full scale not coded as bottom code");

  a_code_mid_toggle: assert property (
    zero_w [*2] |=> code_reg.code != $past(code_reg.code) &&
                    (code_reg.code == `ADM_CODE_MID_LO || code_reg.code == `ADM_CODE_MID_HI))
    else $error("zero input does not alternate midscale codes");

  a_rst_in_bias: assert property (
    (!I_DEMUX_RESET_IN_P || I_DEMUX_RESET_IN_N) |=> !rst_lat_reg)
    else $error("reset latched without a true asserted pair");

  a_rst_in_capture: assert property (
    rst_in_w |=> rst_lat_reg)
    else $error("asserted reset input not captured on next edge");

  a_div_held: assert property (
    rst_lat_reg [*2] |=> cnt_reg == `ADM_CNT_RST && !O_DATA_VALID ||
                         mode_w == adm_pkg::ADM_SINGLE_RATE_MODE)
    else $error("divider left its reset phase during reset");

  a_div_release: assert property (
    s_rst_release |=> cnt_reg == `ADM_CNT_STEP ##1 cnt_reg == 2'h2)
    else $error("divider did not count up from reset phase");

  a_rst_out_lat: assert property (
    O_DEMUX_RESET_OUT == $past(rst_lat_reg, `ADM_RST_OUT_LAT))
    else $error("reset output latency wrong");

  a_rst_out_pair: assert property (
    O_DEMUX_RESET_OUT_N == !O_DEMUX_RESET_OUT)
    else $error("reset output pair not complementary");

  a_dready_pair: assert property (
    O_DREADY_N == !O_DREADY)
    else $error("data-ready pair not complementary");

  a_single_dready: assert property (
    $past(mode_w) == adm_pkg::ADM_SINGLE_RATE_MODE |-> O_DREADY != $past(O_DREADY))
    else $error("single rate data-ready clock did not toggle");

  a_single_aux: assert property (
    mode_w == adm_pkg::ADM_SINGLE_RATE_MODE |=> O_AUX_DATA == $past(O_PRIM_DATA))
    else $error("auxiliary port does not repeat primary one cycle late");

  a_half_pair: assert property (
    mode_w == adm_pkg::ADM_HALF_RATE_MODE && cnt_reg[0] |=>
      O_PRIM_DATA == $past(dly_w.code) && O_AUX_DATA == $past(hist1_reg.code))
    else $error("half rate ports not newer on primary, older on auxiliary");

  a_half_rate: assert property (
    s_half_run ##0 O_DATA_VALID |=> !O_DATA_VALID)
    else $error("half rate ports updated on consecutive cycles");

  a_quarter_drop: assert property (
    mode_w == adm_pkg::ADM_QUARTER_DECIMATE_MODE && cnt_reg == `ADM_CNT_LAST |=>
      O_PRIM_DATA == $past(dly_w.code) && O_AUX_DATA == $past(hist2_reg.code))
    else $error("quarter rate did not skip the middle sample");

  a_update_on_dready: assert property (
    $past(mode_w) != adm_pkg::ADM_SINGLE_RATE_MODE && $past(mode_w, 2) == $past(mode_w) &&
    $changed(O_PRIM_DATA) |-> $rose(O_DREADY))
    else $error("primary port changed away from a data-ready rise");

endmodule

//--- tb/adm_capture_model.sv
// downstream capture model: latches both ports on each update cycle
// assumes i_valid marks the cycle in which new port data stands
`include "adm_consts.svh"

module adm_capture_model (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic [`ADM_CODE_W-1:0] i_prim,
  input  wire logic [`ADM_CODE_W-1:0] i_aux,
  input  wire logic                   i_valid,
  output logic      [`ADM_CODE_W-1:0] o_prim,
  output logic      [`ADM_CODE_W-1:0] o_aux,
  output logic      [15:0]            o_count
);
  timeunit 1ns;
  timeprecision 1ns;

  // samples at the closing edge of the update cycle, as a slow receiver would
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prim  <= 8'h00;
      o_aux   <= 8'h00;
      o_count <= 16'h0000;
    end else if (i_valid) begin
      o_prim  <= i_prim;
      o_aux   <= i_aux;
      o_count <= o_count + 16'h0001;
    end
  end
endmodule

//--- tb/adm_output_demux_reset_sync_bench.sv
// self-checking bench: coding, rate modes, divider phase, demux reset path
// assumes adm_top and adm_capture_model are compiled before it
`include "adm_consts.svh"

module adc_output_demux_reset_sync_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          I_CLK;
  logic                          I_RST;
  logic signed [`ADM_DIFF_W-1:0] I_CONV_DIFF;
  logic                          rp, rn, en, dsel, strap;
  logic        [`ADM_CODE_W-1:0] prim, aux, cap_prim, cap_aux;
  logic                          ovr, drdy, drdy_n, valid, rout, rout_n;
  logic        [15:0]            cap_cnt;
  int                            miscompares, n_checks, cycles, f0, f1;

  adm_top adm_top_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_CONV_DIFF(I_CONV_DIFF),
    .I_DEMUX_RESET_IN_P(rp), .I_DEMUX_RESET_IN_N(rn), .I_DEMUX_ENABLE_SELECT(en),
    .I_DIVIDE_RATIO_SELECT(dsel), .I_PHASE_STRAP(strap), .O_PRIM_DATA(prim),
    .O_AUX_DATA(aux), .O_OVERRANGE(ovr), .O_DREADY(drdy), .O_DREADY_N(drdy_n),
    .O_DATA_VALID(valid), .O_DEMUX_RESET_OUT(rout), .O_DEMUX_RESET_OUT_N(rout_n));

  adm_capture_model adm_capture_model_i (.i_clk(I_CLK), .i_rst(I_RST), .i_prim(prim),
    .i_aux(aux), .i_valid(valid), .o_prim(cap_prim), .o_aux(cap_aux), .o_count(cap_cnt));

  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // inputs move well clear of the sampling edge so the reset pair is stable there
  task automatic tick;
    @(posedge I_CLK);
    #5;
  endtask

  // full reset in half rate; returns edges until the first update
  task automatic hard_reset(input logic s, output int n);
    strap = s;
    en = 1'b1;
    dsel = 1'b0;
    I_RST = 1'b1;
    repeat (20) tick;
    I_RST = 1'b0;
    n = 0;
    while (valid !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
  endtask

  task automatic coding;
    logic [8:0] dv [7];
    logic [7:0] ec [7];
    logic       eo [7];
    dv = '{9'h0C8, 9'h080, 9'h07F, 9'h005, 9'h181, 9'h180, 9'h138};
    ec = '{8'hFF, 8'hFF, 8'hFF, 8'h85, 8'h01, 8'h00, 8'h00};
    eo = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    en = 1'b0;
    dsel = 1'b1;
    for (int i = 0; i < 7; i++) begin
      I_CONV_DIFF = dv[i];
      repeat (10) tick;
      check(prim, ec[i]);
      check(ovr, eo[i]);
      check(valid, 1'b1);
    end
    I_CONV_DIFF = 9'h000;
    repeat (10) tick;
    check(prim ^ aux, 8'hFF);
    check(prim == 8'h7F || prim == 8'h80, 1'b1);
  endtask

  task automatic latency;
    int n;
    I_CONV_DIFF = 9'h010;
    n = 0;
    tick;
    I_CONV_DIFF = 9'h020;
    n = 1;
    while (prim !== 8'h90 && n < 20) begin
      tick;
      n++;
    end
    check(n, 7);
    tick;
    check(aux, 8'h90);
  endtask

  // ramp input; newer sample on primary, older one step back on auxiliary, two back in quarter rate
  task automatic mode_run(input logic e, input logic d, input int step, input int ups);
    logic [15:0] c0;
    en = e;
    dsel = d;
    c0 = 16'h0000;
    for (int i = 0; i < 40; i++) begin
      I_CONV_DIFF = 9'(i);
      tick;
      if (i == 19) c0 = cap_cnt;
      if (e && i > 12 && valid === 1'b1) check(drdy, 1'b1);
      check(drdy_n, !drdy);
    end
    check(cap_cnt - c0, 16'(ups));
    check(cap_prim, 8'(cap_aux + step));
  endtask

  task automatic reset_path(input logic s, input int len);
    int f, t_on, t_off, t_v, nv;
    hard_reset(s, f);
    I_CONV_DIFF = 9'h000;
    rp = 1'b1;
    rn = 1'b1;
    repeat (8) tick;
    check(rout, 1'b0);
    check(cap_cnt > 16'h0002, 1'b1);
    t_on = 0;
    t_off = 0;
    t_v = 0;
    nv = 0;
    rn = 1'b0;
    for (int k = 1; k <= len + 10; k++) begin
      tick;
      if (k == len) {rp, rn} = 2'b01;
      if (rout === 1'b1 && t_on == 0) t_on = k;
      if (rout === 1'b0 && t_on != 0 && t_off == 0) t_off = k;
      if (valid === 1'b1 && k >= 3 && k <= len) nv++;
      if (valid === 1'b1 && k > len && t_v == 0) t_v = k;
      check(rout_n, !rout);
    end
    check(t_on, 6);
    check(t_off, len + 6);
    check(t_v, len + 3);
    check(nv, 0);
  endtask

  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict;
    end
  end

  initial begin
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    {I_RST, rp, rn, en, dsel, strap} = 6'b101000;
    I_CONV_DIFF = 9'h000;
    hard_reset(1'b0, f0);
    hard_reset(1'b1, f1);
    check(f0 - f1, 1);
    coding;
    latency;
    mode_run(1'b0, 1'b1, 1, 20);
    mode_run(1'b1, 1'b0, 1, 10);
    mode_run(1'b1, 1'b1, 2, 5);
    reset_path(1'b0, 3);
    reset_path(1'b1, 8);
    give_verdict;
  end
endmodule
